// >>> src/pca_config_access.v
// partition configuration access: per-space enable flags, narrowing map,
// bandwidth ceilings, selector and error status behind one frame port
// assumes: the caller decodes which space frame was hit and drives accSpace
//
// Contract
// - each space's enable window reached only through that space's frame
// - eight separate enable copies, one per space and instance, each acting on its own space's partitions
// - with instance select, window reaches selected instance and partition
// - with narrowing, window indexes internal id; software sets marker to 1
// - without narrowing, window indexes request id; software sets marker 0
// - reading map after selecting request id returns its internal id
// - out-of-range id or missing marker: map unchanged, range error logged
// - selector marker 1 on map access logs unexpected-internal error
// - map exists only with narrowing support; otherwise reads zero
// - marker bit 16 must be written 1; with 0 association unchanged
// - marker bit reads back last written value
// - internal id in bits 15..0, bounded by reported maximum
// - map accesses ignore the instance field
// - map accesses use selector partition; software keeps marker 0
// - map at frame offset 0x0600, read and write
// - strict ceiling: over-ceiling partition gets no more bandwidth
// - soft ceiling: over-ceiling served only if none under ceiling waits
// - with instance support, ceiling accesses reach selected instance
// - ceiling register 32-bit read/write, one copy per space, instance and partition
// - window bit x is partition (select and 0xFFE0) plus x
// - partition 0 enabled after reset
// - strict select in bit 31, ceiling fraction in bits 15..0
`timescale 1ns/10ps
`default_nettype none
`include "pca_defines.vh"

module pca_config_access #(
   parameter [0:0] HAS_NRW = 1'b1,
   parameter [0:0] INSTANCE_SELECT_SUPPORTED = 1'b1
) (
   // clock and reset
   input wire mclk,
   input wire rstn,
   // frame access port
   input wire accValid,
   input wire accWrite,
   input wire [1:0] accSpace,
   input wire [15:0] accOffset,
   input wire [31:0] accWdata,
   output reg [31:0] accRdata,
   output reg accRvalid,
   // bandwidth requests, two ports packed
   input wire [1:0] reqValid,
   input wire [3:0] reqSpace,
   input wire [1:0] reqInstance,
   input wire [11:0] reqPartition,
   input wire [31:0] reqUsage,
   output wire [1:0] grant
);

   // ------------------------------------------------------------
   // state
   // ------------------------------------------------------------
   reg [31:0] sel [0:3];
   reg [31:0] esr [0:3];
   reg [3:0] mapMark;
   // tables kept in flops: reset must give every entry a known value
   reg [63:0] enFlags [0:7];
   reg [16:0] ceilMem [0:511];
   integer i;
   genvar g;

   // ------------------------------------------------------------
   // selector decode for the accessing space
   // ------------------------------------------------------------
   wire [31:0] curSel;
   wire [15:0] selPart;
   wire selMark;
   wire selInst;
   wire instOk;
   wire partOk;
   wire [2:0] enIdx;
   wire [8:0] ceilIdx;
   wire [15:0] groupBase;
   wire winOk;
   wire [31:0] winRead;

   assign curSel = sel[accSpace];
   assign selPart = curSel[15:0];
   assign selMark = curSel[`PCA_SEL_INT_BIT];
   assign selInst = INSTANCE_SELECT_SUPPORTED ? curSel[`PCA_SEL_RIS_LO] : 1'b0;
   assign instOk = INSTANCE_SELECT_SUPPORTED ? (curSel[`PCA_SEL_RIS_HI:`PCA_SEL_RIS_LO+1] == 3'h0) : 1'b1;
   // same field serves as internal or request id depending on narrowing
   assign partOk = (selPart <= `PCA_PART_MAX);
   assign enIdx = {accSpace, selInst};
   assign ceilIdx = {accSpace, selInst, selPart[5:0]};
   assign groupBase = selPart & `PCA_GROUP_MASK;
   // groups above the last partition read zero and ignore writes
   assign winOk = instOk && (groupBase <= `PCA_PART_MAX);
   // upper group sits in the top half of the 64 flags
   assign winRead = groupBase[5] ? enFlags[enIdx][63:32] : enFlags[enIdx][31:0];

   // ------------------------------------------------------------
   // access classification
   // ------------------------------------------------------------
   wire hitWin;
   wire hitEn;
   wire hitDis;
   wire hitMap;
   wire hitBw;
   wire hitSel;
   wire hitEsr;
   wire [15:0] singlePart;
   wire singleOk;
   wire mapUnexp;
   wire mapRange;
   wire mapWrite;
   wire [3:0] mapRdata;
   wire [3:0] errCode;
   wire accRead;

   assign hitWin = accValid && (accOffset == `PCA_OFS_WIN);
   assign hitEn = accValid && (accOffset == `PCA_OFS_EN);
   assign hitDis = accValid && (accOffset == `PCA_OFS_DIS);
   assign hitMap = accValid && (accOffset == `PCA_OFS_MAP) && HAS_NRW;
   assign hitBw = accValid && (accOffset == `PCA_OFS_BWMAX);
   assign hitSel = accValid && (accOffset == `PCA_OFS_SEL);
   assign hitEsr = accValid && (accOffset == `PCA_OFS_ESR);
   // single enable and disable name the partition in the write data
   assign singlePart = accWdata[15:0];
   assign singleOk = instOk && (singlePart <= `PCA_PART_MAX);
   // every read is answered, an unmapped one with zero
   assign accRead = accValid && !accWrite;

   assign mapUnexp = hitMap && selMark;
   assign mapRange = !accWdata[`PCA_MAP_INT_BIT] || (accWdata[15:0] > `PCA_INT_MAX);
   // instance field plays no part in the map index
   assign mapWrite = hitMap && accWrite && partOk && !selMark && !mapRange;
   assign errCode = mapUnexp ? `PCA_ESR_UNEXP :
                    (hitMap && accWrite && mapRange) ? `PCA_ESR_RANGE : `PCA_ESR_NONE;

   // ------------------------------------------------------------
   // request-side lookups
   // ------------------------------------------------------------
   wire [15:0] lookIdx;
   wire [7:0] lookData;
   wire [1:0] reqEnabled;
   wire [1:0] reqOver;
   wire [1:0] reqStrict;

   generate
      for (g = 0; g < 2; g = g + 1) begin : gPort
         wire [1:0] sp;
         wire [5:0] effId;
         wire ins;
         wire [16:0] ceil;
         assign sp = reqSpace[g*2 +: 2];
         assign ins = INSTANCE_SELECT_SUPPORTED ? reqInstance[g] : 1'b0;
         assign lookIdx[g*8 +: 8] = {sp, reqPartition[g*6 +: 6]};
         // narrowed id steers enable and ceiling when narrowing is present
         assign effId = HAS_NRW ? {2'h0, lookData[g*4 +: 4]} : reqPartition[g*6 +: 6];
         assign reqEnabled[g] = enFlags[{sp, ins}][effId];
         assign ceil = ceilMem[{sp, ins, effId}];
         // usage equal to the ceiling still counts as under it
         assign reqOver[g] = (reqUsage[g*16 +: 16] > ceil[15:0]);
         assign reqStrict[g] = ceil[16];
      end
   endgenerate

   pca_map_table uMap (
      .mclk(mclk),
      .rstn(rstn),
      .cfgIdx({accSpace, selPart[5:0]}),
      .cfgWrite(mapWrite),
      .cfgWdata(accWdata[3:0]),
      .cfgRdata(mapRdata),
      .lookIdx(lookIdx),
      .lookData(lookData)
   );

   // two request ports only; a wider fabric needs a wider arbiter
   pca_bw_grant uGrant (
      .mclk(mclk),
      .rstn(rstn),
      .reqValid(reqValid),
      .reqEnabled(reqEnabled),
      .reqOver(reqOver),
      .reqStrict(reqStrict),
      .grant(grant)
   );

   // ------------------------------------------------------------
   // register writes
   // ------------------------------------------------------------
   always @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         for (i = 0; i < 4; i = i + 1) begin
            sel[i] <= 32'h00000000;
            esr[i] <= 32'h00000000;
         end
         mapMark <= 4'h0;
         for (i = 0; i < 8; i = i + 1) begin
            enFlags[i] <= `PCA_EN_RST;
         end
         for (i = 0; i < 512; i = i + 1) begin
            ceilMem[i] <= `PCA_BW_RST;
         end
      end else begin
         if (hitSel && accWrite) begin
            sel[accSpace] <= accWdata;
         end
         // a new error wins over a same-cycle software clear
         if (errCode != `PCA_ESR_NONE) begin
            esr[accSpace] <= {4'h0, errCode, 24'h000000};
         end else if (hitEsr && accWrite) begin
            esr[accSpace] <= accWdata;
         end
         if (hitMap && accWrite) begin
            mapMark[accSpace] <= accWdata[`PCA_MAP_INT_BIT];
         end
         if (hitWin && accWrite && winOk) begin
            if (groupBase[5]) begin
               enFlags[enIdx][63:32] <= accWdata;
            end else begin
               enFlags[enIdx][31:0] <= accWdata;
            end
         end
         // single enable and disable act on the selected instance only
         if (hitEn && accWrite && singleOk) begin
            enFlags[enIdx][singlePart[5:0]] <= 1'b1;
         end
         if (hitDis && accWrite && singleOk) begin
            enFlags[enIdx][singlePart[5:0]] <= 1'b0;
         end
         // a selector partition past the last one drops the ceiling write
         if (hitBw && accWrite && instOk && partOk) begin
            ceilMem[ceilIdx] <= {accWdata[`PCA_BW_HARD_BIT], accWdata[15:0]};
         end
      end
   end

   // ------------------------------------------------------------
   // read data
   // ------------------------------------------------------------
   reg [31:0] next_accRdata;
   reg [16:0] ceilRead;

   // one shared decode; the offset alone picks the source
   always @* begin
      next_accRdata = 32'h00000000;
      ceilRead = ceilMem[ceilIdx];
      case (accOffset)
         `PCA_OFS_IDR: begin
            next_accRdata[`PCA_IDR_NRW_BIT] = HAS_NRW;
            next_accRdata[`PCA_IDR_RIS_BIT] = INSTANCE_SELECT_SUPPORTED;
            next_accRdata[`PCA_IDR_ENDIS_BIT] = 1'b1;
            next_accRdata[31:16] = `PCA_PART_MAX;
         end
         `PCA_OFS_NRW_IDR: begin
            if (HAS_NRW) begin
               next_accRdata[15:0] = `PCA_INT_MAX;
            end
         end
         `PCA_OFS_ESR: begin
            next_accRdata = esr[accSpace];
         end
         `PCA_OFS_SEL: begin
            next_accRdata = curSel;
         end
         `PCA_OFS_BWMAX: begin
            if (instOk && partOk) begin
               next_accRdata = {ceilRead[16], 15'h0000, ceilRead[15:0]};
            end
         end
         `PCA_OFS_WIN: begin
            if (winOk) begin
               next_accRdata = winRead;
            end
         end
         `PCA_OFS_MAP: begin
            if (HAS_NRW && partOk) begin
               next_accRdata = {15'h0000, mapMark[accSpace], 12'h000, mapRdata};
            end
         end
         default: begin
            next_accRdata = 32'h00000000;
         end
      endcase
   end

   // answer one cycle after the access; write-only and unmapped read zero
   always @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         accRdata <= 32'h00000000;
         accRvalid <= 1'b0;
      end else begin
         accRvalid <= accRead;
         if (accRead) begin
            accRdata <= next_accRdata;
         end
      end
   end

endmodule
`default_nettype wire

// >>> src/pca_defines.vh
// constants for the partition configuration access block
// assumes: included by bare name from every design file of the block
`ifndef PCA_DEFINES_VH
`define PCA_DEFINES_VH

// ------------------------------------------------------------
// frame offsets, same in each of the four space frames
// ------------------------------------------------------------
`define PCA_OFS_IDR 16'h0000
`define PCA_OFS_NRW_IDR 16'h0008
`define PCA_OFS_ESR 16'h00F8
`define PCA_OFS_SEL 16'h0100
`define PCA_OFS_BWMAX 16'h0208
`define PCA_OFS_EN 16'h0300
`define PCA_OFS_DIS 16'h0310
`define PCA_OFS_WIN 16'h0320
`define PCA_OFS_MAP 16'h0600

// ------------------------------------------------------------
// field positions
// ------------------------------------------------------------
`define PCA_SEL_INT_BIT 16
`define PCA_SEL_RIS_LO 24
`define PCA_SEL_RIS_HI 27
`define PCA_IDR_NRW_BIT 0
`define PCA_IDR_RIS_BIT 1
`define PCA_IDR_ENDIS_BIT 2
`define PCA_MAP_INT_BIT 16
`define PCA_BW_HARD_BIT 31
`define PCA_ESR_CODE_LO 24
`define PCA_ESR_CODE_HI 27

// ------------------------------------------------------------
// codes, sizes and reset values
// ------------------------------------------------------------
`define PCA_ESR_NONE 4'h0
`define PCA_ESR_RANGE 4'h1
`define PCA_ESR_UNEXP 4'h2
`define PCA_PART_MAX 16'h003F
`define PCA_INT_MAX 16'h000F
`define PCA_GROUP_MASK 16'hFFE0
`define PCA_EN_RST 64'h0000000000000001
`define PCA_BW_RST 17'h0FFFF
`define PCA_MAP_RST 4'h0

`endif

// >>> src/pca_map_table.v
// narrowing map storage: request partition to internal partition, per space
// assumes: writes arrive already checked; lookups are purely combinational
`timescale 1ns/10ps
`default_nettype none
`include "pca_defines.vh"

module pca_map_table (
   // clock and reset
   input wire mclk,
   input wire rstn,
   // register side
   input wire [7:0] cfgIdx,
   input wire cfgWrite,
   input wire [3:0] cfgWdata,
   output wire [3:0] cfgRdata,
   // request side, two ports packed
   input wire [15:0] lookIdx,
   output wire [7:0] lookData
);

   reg [3:0] mapMem [0:255];
   integer i;
   genvar g;

   // ------------------------------------------------------------
   // storage
   // ------------------------------------------------------------
   always @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         for (i = 0; i < 256; i = i + 1) begin
            mapMem[i] <= `PCA_MAP_RST;
         end
      end else if (cfgWrite) begin
         mapMem[cfgIdx] <= cfgWdata;
      end
   end

   assign cfgRdata = mapMem[cfgIdx];

   generate
      for (g = 0; g < 2; g = g + 1) begin : gLook
         assign lookData[g*4 +: 4] = mapMem[lookIdx[g*8 +: 8]];
      end
   endgenerate

endmodule
`default_nettype wire

// >>> src/pca_bw_grant.v
// bandwidth grant under the per-partition ceiling policy
// assumes: over-ceiling and strict flags are computed by the caller
`timescale 1ns/10ps
`default_nettype none
`include "pca_defines.vh"

module pca_bw_grant (
   // clock and reset
   input wire mclk,
   input wire rstn,
   // per-port qualifiers
   input wire [1:0] reqValid,
   input wire [1:0] reqEnabled,
   input wire [1:0] reqOver,
   input wire [1:0] reqStrict,
   // registered one-hot grant
   output reg [1:0] grant
);

   wire [1:0] live;
   wire [1:0] under;
   wire [1:0] eligible;
   wire anyUnder;
   reg [1:0] next_grant;

   assign live = reqValid & reqEnabled;
   assign under = live & ~reqOver;
   assign anyUnder = |under;
   // strict: never beyond ceiling; soft: only when nobody under ceiling waits
   assign eligible = under | (live & reqOver & ~reqStrict & {2{~anyUnder}});

   // fixed priority keeps the arbiter tiny; port 0 wins ties
   always @* begin
      next_grant = 2'h0;
      if (eligible[0]) begin
         next_grant = 2'h1;
      end else if (eligible[1]) begin
         next_grant = 2'h2;
      end
   end

   always @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         grant <= 2'h0;
      end else begin
         grant <= next_grant;
      end
   end

endmodule
`default_nettype wire

// >>> verif/pca_config_access_chk.sv
// checker for the partition configuration access block, ports only
// assumes: bound to every pca_config_access instance
`timescale 1ns/10ps
`default_nettype none
`include "pca_defines.vh"

module pca_cfg_chk (
   // clock and reset
   input wire logic mclk,
   input wire logic rstn,
   // frame access port
   input wire logic accValid,
   input wire logic accWrite,
   input wire logic [15:0] accOffset,
   input wire logic [31:0] accRdata,
   input wire logic accRvalid,
   // bandwidth ports
   input wire logic [1:0] reqValid,
   input wire logic [1:0] grant
);
   // ------
   // helpers
   // ------
   wire rdTake = accValid && !accWrite;
   wire [15:0] o = accOffset;
   wire mapped = o == `PCA_OFS_IDR || o == `PCA_OFS_NRW_IDR || o == `PCA_OFS_ESR
      || o == `PCA_OFS_SEL || o == `PCA_OFS_BWMAX || o == `PCA_OFS_EN
      || o == `PCA_OFS_DIS || o == `PCA_OFS_WIN || o == `PCA_OFS_MAP;

   default clocking cb @(posedge mclk); endclocking
   default disable iff (!rstn);

   // ------
   // assertions
   // ------
   a_read_answer: assert property (rdTake |=> accRvalid)
      else $error("read not answered one cycle later");
   a_answer_cause: assert property (accRvalid |-> $past(rdTake))
      else $error("read answer without a read");
   a_rdata_holds: assert property (!$past(rdTake) |-> $stable(accRdata))
      else $error("read data moved without a read");
   a_unmapped_raz: assert property (rdTake && !mapped |=> accRdata == 32'h0)
      else $error("unmapped offset read nonzero");
   a_endis_raz: assert property (rdTake && (o == `PCA_OFS_EN || o == `PCA_OFS_DIS)
      |=> accRdata == 32'h0) else $error("single enable or disable read nonzero");
   a_map_fields: assert property (rdTake && o == `PCA_OFS_MAP
      |=> accRdata[31:17] == 15'h0 && accRdata[15:4] == 12'h0)
      else $error("map read outside its fields");
   a_ceiling_fields: assert property (rdTake && o == `PCA_OFS_BWMAX
      |=> accRdata[30:16] == 15'h0) else $error("ceiling reserved bits set");
   a_esr_codes: assert property (rdTake && o == `PCA_OFS_ESR
      |=> accRdata[27:24] <= 4'h2) else $error("unknown error code");
   a_grant_onehot: assert property ($onehot0(grant))
      else $error("more than one grant");
   a_grant_cause: assert property ((grant & ~$past(reqValid)) == 2'h0)
      else $error("grant without request");
endmodule

bind pca_config_access pca_cfg_chk u_chk (
   .mclk(mclk),
   .rstn(rstn),
   .accValid(accValid),
   .accWrite(accWrite),
   .accOffset(accOffset),
   .accRdata(accRdata),
   .accRvalid(accRvalid),
   .reqValid(reqValid),
   .grant(grant)
);
`default_nettype wire

// >>> verif/pca_config_access_test.sv
// self-checking bench for the partition configuration access block
// assumes: checker bound from its own file; both features present
`timescale 1ns/10ps
`default_nettype none
`include "pca_defines.vh"

module pca_config_access_test;
   // ------
   // stimulus and observation
   // ------
   reg mclk = 1'b0;
   reg rstn = 1'b0;
   reg accValid = 1'b0;
   reg accWrite = 1'b0;
   reg [1:0] accSpace = 2'h0;
   reg [15:0] accOffset = 16'h0;
   reg [31:0] accWdata = 32'h0;
   reg [1:0] reqValid = 2'h0;
   reg [11:0] reqPartition = 12'h0;
   reg [3:0] reqSpace = 4'h0;
   reg [1:0] reqInstance = 2'h0;
   reg [31:0] reqUsage = 32'h0;
   wire [31:0] accRdata;
   wire accRvalid;
   wire [1:0] grant;
   integer nErrors = 0;
   integer checksDone = 0;
   integer i;
   reg [31:0] d;

   always #50 mclk = ~mclk;

   pca_config_access #(.HAS_NRW(1'b1), .INSTANCE_SELECT_SUPPORTED(1'b1)) u_dut (
      .mclk(mclk),
      .rstn(rstn),
      .accValid(accValid),
      .accWrite(accWrite),
      .accSpace(accSpace),
      .accOffset(accOffset),
      .accWdata(accWdata),
      .accRdata(accRdata),
      .accRvalid(accRvalid),
      .reqValid(reqValid),
      .reqSpace(reqSpace),
      .reqInstance(reqInstance),
      .reqPartition(reqPartition),
      .reqUsage(reqUsage),
      .grant(grant)
   );

   // ------
   // tasks
   // ------
   task chk(input [31:0] seen, input [31:0] exp);
      begin
         checksDone = checksDone + 1;
         if (seen !== exp) begin
            nErrors = nErrors + 1;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
         end
      end
   endtask

   // one access, then an idle cycle so the answer is looked at alone
   task acc(input wr, input [1:0] sp, input [15:0] ofs, input [31:0] w);
      begin
         accValid = 1'b1;
         accWrite = wr;
         accSpace = sp;
         accOffset = ofs;
         accWdata = w;
         @(posedge mclk);
         #1;
         accValid = 1'b0;
         d = accRdata;
         chk({31'h0, accRvalid}, {31'h0, ~wr});
         @(posedge mclk);
         #1;
      end
   endtask

   task wr(input [1:0] sp, input [15:0] ofs, input [31:0] w);
      acc(1'b1, sp, ofs, w);
   endtask

   task rc(input [1:0] sp, input [15:0] ofs, input [31:0] exp);
      begin
         acc(1'b0, sp, ofs, 32'h0);
         chk(d, exp);
      end
   endtask

   // error code compare, then clear for the next case
   task ec(input [1:0] sp, input [3:0] code);
      begin
         acc(1'b0, sp, `PCA_OFS_ESR, 32'h0);
         chk({28'h0, d[27:24]}, {28'h0, code});
         wr(sp, `PCA_OFS_ESR, 32'h0);
      end
   endtask

   task gq(input [1:0] v, input [11:0] p, input [31:0] u, input [1:0] exp);
      begin
         reqValid = v;
         reqPartition = p;
         reqUsage = u;
         @(posedge mclk);
         #1;
         chk({30'h0, grant}, {30'h0, exp});
         reqValid = 2'h0;
         @(posedge mclk);
         #1;
      end
   endtask

   task conclude;
      begin
         $display("checks=%0d errors=%0d", checksDone, nErrors);
         if (nErrors == 0 && checksDone > 0)
            $display("SIMULATION PASSED");
         else
            $display("SIMULATION FAILED");
         $finish;
      end
   endtask

   // ------
   // sequence
   // ------
   initial begin
      repeat (5) @(posedge mclk);
      #1;
      rstn = 1'b1;
      for (i = 0; i < 4; i = i + 1) begin
         rc(i[1:0], `PCA_OFS_WIN, 32'h1);
         rc(i[1:0], `PCA_OFS_MAP, 32'h0);
      end
      rc(2'h0, `PCA_OFS_BWMAX, 32'h0000FFFF);
      rc(2'h0, 16'h0004, 32'h0);
      wr(2'h1, `PCA_OFS_SEL, 32'h00010000);
      wr(2'h1, `PCA_OFS_WIN, 32'hA5A50003);
      for (i = 0; i < 4; i = i + 1)
         rc(i[1:0], `PCA_OFS_WIN, (i == 1) ? 32'hA5A50003 : 32'h1);
      wr(2'h1, `PCA_OFS_SEL, 32'h00010025);
      wr(2'h1, `PCA_OFS_WIN, 32'h8000F00F);
      wr(2'h1, `PCA_OFS_SEL, 32'h0001003F);
      rc(2'h1, `PCA_OFS_WIN, 32'h8000F00F);
      wr(2'h1, `PCA_OFS_SEL, 32'h0001001F);
      rc(2'h1, `PCA_OFS_WIN, 32'hA5A50003);
      wr(2'h1, `PCA_OFS_SEL, 32'h01010000);
      rc(2'h1, `PCA_OFS_WIN, 32'h1);
      wr(2'h1, `PCA_OFS_WIN, 32'h6);
      rc(2'h1, `PCA_OFS_WIN, 32'h6);
      wr(2'h1, `PCA_OFS_SEL, 32'h02010000);
      rc(2'h1, `PCA_OFS_WIN, 32'h0);
      wr(2'h1, `PCA_OFS_SEL, 32'h00010000);
      rc(2'h1, `PCA_OFS_WIN, 32'hA5A50003);
      wr(2'h2, `PCA_OFS_SEL, 32'h00010000);
      wr(2'h2, `PCA_OFS_EN, 32'h5);
      wr(2'h2, `PCA_OFS_DIS, 32'h0);
      rc(2'h2, `PCA_OFS_WIN, 32'h20);
      rc(2'h2, `PCA_OFS_EN, 32'h0);
      wr(2'h0, `PCA_OFS_SEL, 32'h00000005);
      wr(2'h0, `PCA_OFS_MAP, 32'h00010003);
      rc(2'h0, `PCA_OFS_MAP, 32'h00010003);
      wr(2'h0, `PCA_OFS_MAP, 32'h00000007);
      rc(2'h0, `PCA_OFS_MAP, 32'h00000003);
      ec(2'h0, 4'h1);
      wr(2'h0, `PCA_OFS_MAP, 32'h00010010);
      rc(2'h0, `PCA_OFS_MAP, 32'h00010003);
      ec(2'h0, 4'h1);
      wr(2'h0, `PCA_OFS_SEL, 32'h01000005);
      rc(2'h0, `PCA_OFS_MAP, 32'h00010003);
      wr(2'h0, `PCA_OFS_SEL, 32'h00010005);
      wr(2'h0, `PCA_OFS_MAP, 32'h00010009);
      rc(2'h0, `PCA_OFS_MAP, 32'h00010003);
      ec(2'h0, 4'h2);
      wr(2'h0, `PCA_OFS_SEL, 32'h00010000);
      wr(2'h0, `PCA_OFS_WIN, 32'h29);
      wr(2'h0, `PCA_OFS_SEL, 32'h00010003);
      wr(2'h0, `PCA_OFS_BWMAX, 32'h80001000);
      rc(2'h0, `PCA_OFS_BWMAX, 32'h80001000);
      rc(2'h1, `PCA_OFS_BWMAX, 32'h0000FFFF);
      gq(2'h1, 12'h005, 32'h00002000, 2'h0);
      gq(2'h3, 12'h005, 32'h00002000, 2'h2);
      gq(2'h1, 12'h005, 32'h00000800, 2'h1);
      gq(2'h1, 12'h007, 32'h0, 2'h1);
      reqSpace = 4'h2;
      gq(2'h1, 12'h007, 32'h0, 2'h0);
      reqSpace = 4'h1;
      gq(2'h1, 12'h000, 32'h0, 2'h1);
      reqInstance = 2'h1;
      gq(2'h1, 12'h000, 32'h0, 2'h0);
      reqInstance = 2'h0;
      reqSpace = 4'h0;
      wr(2'h0, `PCA_OFS_BWMAX, 32'h00001000);
      gq(2'h1, 12'h005, 32'h00002000, 2'h1);
      gq(2'h3, 12'h005, 32'h00002000, 2'h2);
      wr(2'h0, `PCA_OFS_SEL, 32'h01010003);
      rc(2'h0, `PCA_OFS_BWMAX, 32'h0000FFFF);
      conclude;
   end

   // ------
   // watchdog, far beyond the expected run
   // ------
   initial begin
      #200000;
      nErrors = nErrors + 1;
      conclude;
   end
endmodule
`default_nettype wire
